/* File: core/usbis_pkg.sv */
// Package for the low half of the interrupt status word of the USB core.
// Assumes a 100 MHz core clock; holds bit positions, reset values and times.
package usbis_pkg;
   // Clock rate in MHz
   localparam int CLK_MHZ = 100;
   // Bit positions inside the status word
   localparam int BIT_ROLE = 0;
   localparam int BIT_SOF = 3;
   localparam int BIT_RXP = 4;
   localparam int BIT_NPTX = 5;
   localparam int BIT_INAK = 6;
   localparam int BIT_ONAK = 7;
   localparam int BIT_RSV_LO = 8;
   localparam int BIT_RSV_HI = 9;
   localparam int BIT_EARLY = 10;
   localparam int BIT_SUSP = 11;
   localparam int BIT_BRST = 12;
   // Reset value of the transmit-space flag
   localparam logic NPTX_RST = 1'h1;
   // Line idle time before the early-idle flag, in microseconds
   localparam int EARLY_IDLE_US = 3000;
   // Line idle time before the core is suspended, in microseconds
   localparam int SUSPEND_IDLE_US = 6000;
   // Least single-ended-zero time taken as a bus reset, in nanoseconds
   localparam int BUS_RST_NS = 2500;
   // Cycles of single-ended zero for a bus reset, rounded up
   localparam int BUS_RST_CYC = (BUS_RST_NS * CLK_MHZ + 999) / 1000;
   // Width of the idle counter
   localparam int IDLE_W = 20;
   // Width of the single-ended-zero counter
   localparam int SE0_W = 9;
   // Width of the frame number
   localparam int FRAME_W = 11;
endpackage : usbis_pkg

/* File: core/usbis_sync.sv */
// Two flip-flop synchroniser for the USB line pins.
// Assumes the pins are asynchronous to core_clk.
`timescale 1ns/1ps
module usbis_sync #(
   parameter int W = 2
) (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic [W-1:0] pin_in,
   output logic [W-1:0] pin_sync
);
   // All state of the synchroniser
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } usbis_sync_s;
   usbis_sync_s st_r;
   usbis_sync_s st_nxt;

   // Each bit shifts through two stages; only stage two is read
   always_comb begin
      st_nxt = st_r;
      for (int i = 0; i < W; i++) begin
         st_nxt.s1[i] = pin_in[i];
         st_nxt.s2[i] = st_r.s1[i];
      end
   end

   // Registers the state
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign pin_sync = st_r.s2;
endmodule : usbis_sync

/* File: core/usbis_core.sv */
// Low half of the USB core interrupt status word: bits 12 down to 3 and role.
// Assumes line pins are asynchronous; all other inputs come from core_clk logic.
`timescale 1ns/1ps
module usbis_core #(
   parameter int EARLY_CYC = usbis_pkg::EARLY_IDLE_US * usbis_pkg::CLK_MHZ,
   parameter int SUSP_CYC = usbis_pkg::SUSPEND_IDLE_US * usbis_pkg::CLK_MHZ
) (
   input wire logic core_clk,
   input wire logic rst_n,
   // USB line pins, asynchronous
   input wire logic usb_dp,
   input wire logic usb_dm,
   // Operating role and speed
   input wire logic host_role,
   input wire logic fs_mode,
   // Status word access
   input wire logic reg_wr,
   input wire logic [31:0] reg_wdata,
   output logic [31:0] reg_rdata,
   // Mask word, one means unmasked
   input wire logic [31:0] int_mask,
   output logic irq_out,
   // Device control strobes for the global NAKs
   input wire logic set_gout_nak,
   input wire logic clr_gout_nak,
   input wire logic set_gin_nak,
   input wire logic clr_gin_nak,
   input wire logic out_xfer_busy,
   // Endpoint handshake choice
   input wire logic ep_stall,
   input wire logic ep_nak,
   output logic hs_stall,
   output logic hs_nak,
   // Transmit FIFO and request queue state
   input wire logic np_half_empty,
   input wire logic np_empty,
   input wire logic np_lvl_full,
   input wire logic npq_space,
   // Receive FIFO packet count
   input wire logic [7:0] rx_pkt_count,
   // Start-of-frame events
   input wire logic sof_tx,
   input wire logic sof_rx,
   input wire logic [usbis_pkg::FRAME_W-1:0] sof_rx_frame,
   output logic [usbis_pkg::FRAME_W-1:0] frame_num,
   // Suspended state of the core
   output logic suspended
);
   // Synchronised line pins
   logic [1:0] line_s;

   // Pins pass two flops first
   usbis_sync #(.W(2)) u_sync (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .pin_in({usb_dp, usb_dm}),
      .pin_sync(line_s)
   );

   // All state of the block
   typedef struct packed {
      logic [usbis_pkg::IDLE_W-1:0] idle_cnt; // Cycles of J state
      logic [usbis_pkg::SE0_W-1:0] se0_cnt; // Cycles of SE0
      logic brst; // Bus reset flag
      logic susp; // Suspend flag
      logic early; // Early idle flag
      logic sof; // Start of frame flag
      logic onak_req; // OUT NAK requested
      logic onak_eff; // OUT NAK in force
      logic inak_req; // IN NAK requested
      logic inak_eff; // IN NAK in force
      logic nptx; // Transmit space flag
      logic rxp; // Receive pending flag
      logic role; // Current role
      logic irq; // Interrupt request
      logic [31:0] rdata; // Read word
      logic [usbis_pkg::FRAME_W-1:0] frame; // Frame number
      logic suspended; // Suspended state
      logic hs_stall; // Stall handshake chosen
      logic hs_nak; // NAK handshake chosen
   } usbis_state_s;

   usbis_state_s st_r;
   usbis_state_s st_nxt;

   // Line condition decode
   logic line_j;
   logic line_se0;
   // Hardware set events
   logic ev_brst;
   logic ev_susp;
   logic ev_early;
   logic ev_sof;
   // Software clear strobes
   logic clr_brst;
   logic clr_susp;
   logic clr_early;
   logic clr_sof;
   // Status word as it stands now
   logic [31:0] stat_now;

   // Line decode and events
   always_comb begin
      line_j = line_s[1] & ~line_s[0];
      line_se0 = ~line_s[1] & ~line_s[0];
      // Device-only events held off in host role
      ev_brst = !host_role && line_se0 &&
                (st_r.se0_cnt == usbis_pkg::SE0_W'(usbis_pkg::BUS_RST_CYC - 1));
      ev_early = !host_role && line_j &&
                 (st_r.idle_cnt == usbis_pkg::IDLE_W'(EARLY_CYC - 1));
      ev_susp = !host_role && line_j &&
                (st_r.idle_cnt == usbis_pkg::IDLE_W'(SUSP_CYC - 1));
      // SOF only counted at full speed
      ev_sof = fs_mode && (host_role ? sof_tx : sof_rx);
      clr_brst = reg_wr && reg_wdata[usbis_pkg::BIT_BRST];
      clr_susp = reg_wr && reg_wdata[usbis_pkg::BIT_SUSP];
      clr_early = reg_wr && reg_wdata[usbis_pkg::BIT_EARLY];
      clr_sof = reg_wr && reg_wdata[usbis_pkg::BIT_SOF];
   end

   // Assembles the status word
   always_comb begin
      stat_now = 32'h0;
      stat_now[usbis_pkg::BIT_BRST] = st_r.brst;
      stat_now[usbis_pkg::BIT_SUSP] = st_r.susp;
      stat_now[usbis_pkg::BIT_EARLY] = st_r.early;
      // Reserved bits stay zero
      stat_now[usbis_pkg::BIT_RSV_HI:usbis_pkg::BIT_RSV_LO] = 2'h0;
      stat_now[usbis_pkg::BIT_ONAK] = st_r.onak_eff;
      stat_now[usbis_pkg::BIT_INAK] = st_r.inak_eff;
      stat_now[usbis_pkg::BIT_NPTX] = st_r.nptx;
      stat_now[usbis_pkg::BIT_RXP] = st_r.rxp;
      stat_now[usbis_pkg::BIT_SOF] = st_r.sof;
      stat_now[usbis_pkg::BIT_ROLE] = st_r.role;
   end

   // Next-state logic
   always_comb begin
      st_nxt = st_r;
      // Idle counter runs while the line sits in J, saturating
      if (!line_j) begin
         st_nxt.idle_cnt = '0;
      end else if (st_r.idle_cnt != '1) begin
         st_nxt.idle_cnt = st_r.idle_cnt + 1'h1;
      end
      // SE0 counter runs while both lines are low, saturating
      if (!line_se0) begin
         st_nxt.se0_cnt = '0;
      end else if (st_r.se0_cnt != '1) begin
         st_nxt.se0_cnt = st_r.se0_cnt + 1'h1;
      end
      // Sticky flags: a set in the clear cycle wins
      st_nxt.brst = ev_brst | (st_r.brst & ~clr_brst);
      st_nxt.susp = ev_susp | (st_r.susp & ~clr_susp);
      st_nxt.early = ev_early | (st_r.early & ~clr_early);
      st_nxt.sof = ev_sof | (st_r.sof & ~clr_sof);
      // Frame number follows each SOF received in device role
      if (!host_role && sof_rx) begin
         st_nxt.frame = sof_rx_frame;
      end
      // Suspended after long idle, left on any activity
      if (!line_j) begin
         st_nxt.suspended = 1'h0;
      end else if (ev_susp) begin
         st_nxt.suspended = 1'h1;
      end
      // OUT NAK request, then in force once no OUT transfer runs
      if (clr_gout_nak) begin
         st_nxt.onak_req = 1'h0;
         st_nxt.onak_eff = 1'h0;
      end else begin
         if (set_gout_nak && !host_role) begin
            st_nxt.onak_req = 1'h1;
         end
         if (st_r.onak_req && !out_xfer_busy) begin
            st_nxt.onak_eff = 1'h1;
         end
      end
      // IN NAK request sampled one cycle later
      if (clr_gin_nak) begin
         st_nxt.inak_req = 1'h0;
         st_nxt.inak_eff = 1'h0;
      end else begin
         if (set_gin_nak && !host_role) begin
            st_nxt.inak_req = 1'h1;
         end
         if (st_r.inak_req) begin
            st_nxt.inak_eff = 1'h1;
         end
      end
      // Stall takes precedence over any NAK
      st_nxt.hs_stall = ep_stall;
      st_nxt.hs_nak = !ep_stall && (ep_nak || st_r.inak_eff);
      // Transmit space: level picks threshold, queue must have room
      st_nxt.nptx = (np_lvl_full ? np_empty : np_half_empty) && npq_space;
      // Receive pending while any packet waits
      st_nxt.rxp = (rx_pkt_count != 8'h0);
      st_nxt.role = host_role;
      // Request from unmasked flags; mask leaves flags alone
      st_nxt.irq = |(stat_now & int_mask & ~32'h1);
      st_nxt.rdata = stat_now;
   end

   // Registers the state
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         st_r <= '0;
         st_r.nptx <= usbis_pkg::NPTX_RST;
      end else begin
         st_r <= st_nxt;
      end
   end

   // Outputs straight from flops
   assign reg_rdata = st_r.rdata;
   assign irq_out = st_r.irq;
   assign hs_stall = st_r.hs_stall;
   assign hs_nak = st_r.hs_nak;
   assign frame_num = st_r.frame;
   assign suspended = st_r.suspended;

   // Checks on the block
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!rst_n);

   // Set of bus reset lands even under a clear
   a_brst_set_wins: assert property (ev_brst |=> st_r.brst)
      else $error("bus reset flag lost its set");
   // Write one without an event clears the flag
   a_w1c_clears: assert property (clr_sof && !ev_sof |=> !st_r.sof)
      else $error("sof flag not cleared by write one");
   // Bus reset flag never rises in host role
   a_host_no_dev: assert property ($rose(st_r.brst) |-> !$past(host_role))
      else $error("bus reset flag rose in host role");
   // Early flag rises after the exact idle count
   a_early_time: assert property ($rose(st_r.early) |->
      $past(st_r.idle_cnt) == usbis_pkg::IDLE_W'(EARLY_CYC - 1))
      else $error("early idle flag at wrong time");
   // SOF flag rises only at full speed
   a_sof_fs: assert property ($rose(st_r.sof) |-> $past(fs_mode))
      else $error("sof flag rose outside full speed");
   // Stall chosen and NAK suppressed
   a_stall_first: assert property (ep_stall |=> hs_stall && !hs_nak)
      else $error("nak chosen over stall");
   // Reserved bits read zero
   a_resv_zero: assert property (
      reg_rdata[usbis_pkg::BIT_RSV_HI:usbis_pkg::BIT_RSV_LO] == 2'h0)
      else $error("reserved bits not zero");
   // Unmasked flag raises the request next cycle
   a_irq_mask: assert property (st_r.brst && int_mask[usbis_pkg::BIT_BRST] |=> irq_out)
      else $error("unmasked flag gave no request");
   // OUT NAK stays in force until its clear
   a_onak_hold: assert property (st_r.onak_eff && !clr_gout_nak |=> st_r.onak_eff)
      else $error("out nak flag dropped without clear");
   // Pending packet shows in the read word two cycles on
   a_rx_pend: assert property (rx_pkt_count != 8'h0 |=>
      ##1 reg_rdata[usbis_pkg::BIT_RXP])
      else $error("rx pending not shown");
   // IN NAK in force two cycles after a device request
   a_inak_rise: assert property (set_gin_nak && !host_role && !clr_gin_nak
      ##1 !clr_gin_nak |=> st_r.inak_eff)
      else $error("in nak not in force");
   // Bus reset flag rises after the exact single-ended-zero count
   a_brst_time: assert property ($rose(st_r.brst) |->
      $past(st_r.se0_cnt) == usbis_pkg::SE0_W'(usbis_pkg::BUS_RST_CYC - 1))
      else $error("bus reset flag at wrong time");
   // Suspend flag and suspended state follow the long idle event
   a_susp_set: assert property (ev_susp |=> st_r.susp && suspended)
      else $error("suspend not taken after long idle");
   // Suspended state entered only after the long idle count
   a_susp_time: assert property ($rose(st_r.suspended) |->
      $past(st_r.idle_cnt) == usbis_pkg::IDLE_W'(SUSP_CYC - 1))
      else $error("suspended entered at wrong time");
   // Early idle flag never rises in host role
   a_host_no_early: assert property ($rose(st_r.early) |-> !$past(host_role))
      else $error("early idle flag rose in host role");
   // OUT NAK takes effect once requested and no OUT transfer runs
   a_onak_rise: assert property (st_r.onak_req && !out_xfer_busy && !clr_gout_nak
      |=> st_r.onak_eff)
      else $error("out nak not in force");
   // Clear control drops the OUT NAK flag
   a_onak_clear: assert property (clr_gout_nak |=> !st_r.onak_eff)
      else $error("out nak flag not cleared");
   // Clear control drops the IN NAK flag
   a_inak_clear: assert property (clr_gin_nak |=> !st_r.inak_eff)
      else $error("in nak flag not cleared");
   // Transmit space at the fully empty threshold with queue room
   a_nptx_full: assert property (np_lvl_full && np_empty && npq_space
      |=> st_r.nptx)
      else $error("tx space missing at full empty");
   // Transmit space at the half empty threshold with queue room
   a_nptx_half: assert property (!np_lvl_full && np_half_empty && npq_space
      |=> st_r.nptx)
      else $error("tx space missing at half empty");
   // Fully empty level ignores a half empty FIFO
   a_nptx_lvl: assert property (np_lvl_full && !np_empty |=> !st_r.nptx)
      else $error("tx space shown above full empty level");
   // No transmit space without queue room
   a_nptx_noq: assert property (!npq_space |=> !st_r.nptx)
      else $error("tx space shown without queue room");
   // Empty receive FIFO shows no pending packet
   a_rx_none: assert property (rx_pkt_count == 8'h0 |=> !st_r.rxp)
      else $error("rx pending with empty fifo");
   // Sent SOF at full speed sets the flag in host role
   a_sof_host: assert property (host_role && fs_mode && sof_tx |=> st_r.sof)
      else $error("sent sof not flagged");
   // Received SOF at full speed sets the flag in device role
   a_sof_dev: assert property (!host_role && fs_mode && sof_rx |=> st_r.sof)
      else $error("received sof not flagged");
   // Received frame number becomes readable
   a_frame_cap: assert property (!host_role && sof_rx |=>
      frame_num == $past(sof_rx_frame))
      else $error("frame number not captured");
   // Role bit follows the operating role
   a_role_bit: assert property (st_r.role == $past(host_role))
      else $error("role bit wrong");
   // Masked flag still sets on its event
   a_mask_keeps: assert property (ev_brst && !int_mask[usbis_pkg::BIT_BRST] |=>
      st_r.brst)
      else $error("masked flag did not set");
   // No request while every flag is masked
   a_irq_quiet: assert property ((stat_now & int_mask & ~32'h1) == 32'h0 |=> !irq_out)
      else $error("request with all flags masked");
endmodule : usbis_core

/* File: test/usbis_line_model.sv */
// Line partner: a far USB party that holds the lines idle, in reset or busy.
// Assumes the core synchronises the pins; lines change at clock edges only.
`timescale 1ns/1ps
module usbis_line_model (
   input wire logic core_clk,
   input wire logic [1:0] line_cmd,
   output logic usb_dp,
   output logic usb_dm
);
   // Toggle that alternates J and K while the line is busy
   logic tgl_r;
   // Free toggle, so busy traffic never shows a long J stretch
   always @(posedge core_clk) begin
      tgl_r <= ~tgl_r;
   end
   initial tgl_r = 1'h0;
   // 0 idle J, 1 single-ended zero, 2 busy traffic
   assign usb_dp = (line_cmd == 2'h0) | ((line_cmd == 2'h2) & tgl_r);
   assign usb_dm = (line_cmd == 2'h2) & ~tgl_r;
endmodule : usbis_line_model

/* File: test/usbis_tb.sv */
// Self-checking bench for the low half of the USB interrupt status word.
// Assumes usbis_core with short idle counts and the line partner model.
`timescale 1ns/1ps
module testbench;
   logic core_clk, rst_n, host_role, fs_mode, reg_wr, irq_out, hs_stall, hs_nak, suspended;
   logic usb_dp, usb_dm, set_gout_nak, clr_gout_nak, set_gin_nak, clr_gin_nak, out_xfer_busy;
   logic ep_stall, ep_nak, np_half_empty, np_empty, np_lvl_full, npq_space, sof_tx, sof_rx;
   logic [31:0] reg_wdata, reg_rdata, int_mask;
   logic [7:0] rx_pkt_count;
   logic [usbis_pkg::FRAME_W-1:0] sof_rx_frame, frame_num;
   // Line state asked of the partner
   logic [1:0] line_cmd;
   int fail_count, cmp_count;
   usbis_line_model usbis_line_model_i (.core_clk(core_clk), .line_cmd(line_cmd),
      .usb_dp(usb_dp), .usb_dm(usb_dm));
   usbis_core #(.EARLY_CYC(20), .SUSP_CYC(40)) usbis_core_i (.core_clk(core_clk),
      .rst_n(rst_n), .usb_dp(usb_dp), .usb_dm(usb_dm), .host_role(host_role),
      .fs_mode(fs_mode), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .int_mask(int_mask), .irq_out(irq_out), .set_gout_nak(set_gout_nak),
      .clr_gout_nak(clr_gout_nak), .set_gin_nak(set_gin_nak), .clr_gin_nak(clr_gin_nak),
      .out_xfer_busy(out_xfer_busy), .ep_stall(ep_stall), .ep_nak(ep_nak),
      .hs_stall(hs_stall), .hs_nak(hs_nak), .np_half_empty(np_half_empty),
      .np_empty(np_empty), .np_lvl_full(np_lvl_full), .npq_space(npq_space),
      .rx_pkt_count(rx_pkt_count), .sof_tx(sof_tx), .sof_rx(sof_rx),
      .sof_rx_frame(sof_rx_frame), .frame_num(frame_num), .suspended(suspended));
   // Clock of 10 ns period
   initial begin
      core_clk = 1'h0;
      forever #5 core_clk = ~core_clk;
   end
   // Wait n edges, then step just past the edge
   task automatic cyc(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask : cyc
   // Compare seen against expected
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      cmp_count++;
      if (s !== e) begin
         fail_count++;
         $display("[FAIL] t=%0t seen=%0h exp=%0h", $time, s, e);
      end
   endtask : chk
   // One status word write, then let it land
   task automatic wr(input logic [31:0] d);
      reg_wdata = d;
      reg_wr = 1'h1;
      cyc(1);
      reg_wr = 1'h0;
      cyc(2);
   endtask : wr
   // Verdict and end of run
   task automatic final_report();
      $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : final_report
   // Bus reset seen, zero write keeps it, one write clears it
   task automatic t_bus_reset();
      line_cmd = 2'h1;
      cyc(260);
      line_cmd = 2'h2;
      cyc(4);
      chk(reg_rdata[12], 1'h1);
      wr(32'h0000_0000);
      chk(reg_rdata[12], 1'h1);
      wr(32'h0000_1000);
      chk(reg_rdata[12], 1'h0);
   endtask : t_bus_reset
   // Idle J: early flag first, then suspend, then wake on traffic
   task automatic t_idle();
      wr(32'h0000_0C00);
      line_cmd = 2'h0;
      cyc(30);
      chk(reg_rdata[11:10], 2'h1);
      chk(suspended, 1'h0);
      cyc(25);
      chk(reg_rdata[11:10], 2'h3);
      chk(suspended, 1'h1);
      line_cmd = 2'h2;
      cyc(6);
      chk(suspended, 1'h0);
   endtask : t_idle
   // Global NAKs: OUT waits for idle transfer, clears on clear; host ignores set
   task automatic t_nak();
      out_xfer_busy = 1'h1;
      set_gout_nak = 1'h1;
      set_gin_nak = 1'h1;
      cyc(1);
      set_gout_nak = 1'h0;
      set_gin_nak = 1'h0;
      cyc(4);
      chk(reg_rdata[7:6], 2'h1);
      out_xfer_busy = 1'h0;
      cyc(4);
      chk(reg_rdata[7:6], 2'h3);
      clr_gout_nak = 1'h1;
      clr_gin_nak = 1'h1;
      cyc(1);
      clr_gout_nak = 1'h0;
      clr_gin_nak = 1'h0;
      cyc(3);
      chk(reg_rdata[7:6], 2'h0);
      host_role = 1'h1;
      set_gin_nak = 1'h1;
      cyc(1);
      set_gin_nak = 1'h0;
      cyc(4);
      chk(reg_rdata[7:6], 2'h0);
      chk(reg_rdata[0], 1'h1);
      host_role = 1'h0;
      cyc(3);
      chk(reg_rdata[0], 1'h0);
   endtask : t_nak
   // Stall wins over NAK
   task automatic t_handshake();
      ep_stall = 1'h1;
      ep_nak = 1'h1;
      cyc(2);
      chk({hs_stall, hs_nak}, 2'h2);
      ep_stall = 1'h0;
      cyc(2);
      chk({hs_stall, hs_nak}, 2'h1);
      ep_nak = 1'h0;
   endtask : t_handshake
   // Every threshold, level and queue combination
   task automatic t_tx_space();
      // Expected flag per {level, half empty, empty, queue room} code
      logic [15:0] nptx_exp;
      nptx_exp = 16'h88A0;
      for (int i = 0; i < 16; i++) begin
         {np_lvl_full, np_half_empty, np_empty, npq_space} = 4'(i);
         cyc(3);
         chk(reg_rdata[5], nptx_exp[i]);
      end
   endtask : t_tx_space
   // Receive pending and mask against request
   task automatic t_rx_irq();
      rx_pkt_count = 8'h01;
      int_mask = 32'h0000_0000;
      cyc(3);
      chk(reg_rdata[4], 1'h1);
      chk(irq_out, 1'h0);
      int_mask = 32'h0000_0010;
      cyc(3);
      chk(irq_out, 1'h1);
      rx_pkt_count = 8'hFF;
      cyc(3);
      chk(reg_rdata[4], 1'h1);
      rx_pkt_count = 8'h00;
      cyc(3);
      chk(reg_rdata[4], 1'h0);
      chk(irq_out, 1'h0);
      int_mask = 32'h0000_0000;
   endtask : t_rx_irq
   // Start of frame in host and device roles, full speed only
   task automatic t_sof();
      host_role = 1'h1;
      wr(32'h0000_0008);
      sof_tx = 1'h1;
      cyc(1);
      sof_tx = 1'h0;
      cyc(3);
      chk(reg_rdata[3], 1'h1);
      wr(32'h0000_0008);
      chk(reg_rdata[3], 1'h0);
      fs_mode = 1'h0;
      sof_tx = 1'h1;
      cyc(1);
      sof_tx = 1'h0;
      cyc(3);
      chk(reg_rdata[3], 1'h0);
      fs_mode = 1'h1;
      host_role = 1'h0;
      sof_rx = 1'h1;
      sof_rx_frame = 11'h5A5;
      cyc(1);
      sof_rx = 1'h0;
      cyc(3);
      chk(reg_rdata[3], 1'h1);
      chk(frame_num, 11'h5A5);
   endtask : t_sof
   // Watchdog well beyond the expected run time
   initial begin
      #100000;
      fail_count++;
      final_report();
   end
   // Main sequence
   initial begin
      fail_count = 0;
      cmp_count = 0;
      {rst_n, host_role, reg_wr, set_gout_nak, clr_gout_nak, set_gin_nak} = '0;
      {clr_gin_nak, out_xfer_busy, ep_stall, ep_nak, np_empty, np_lvl_full} = '0;
      {sof_tx, sof_rx, reg_wdata, int_mask, rx_pkt_count, sof_rx_frame} = '0;
      {fs_mode, np_half_empty, npq_space} = 3'h7;
      line_cmd = 2'h2;
      cyc(6);
      rst_n = 1'h1;
      cyc(1);
      // Start-of-frame bit is not judged right after power-on
      chk(reg_rdata & 32'hFFFF_FFF7, 32'h0000_0020);
      t_bus_reset();
      t_idle();
      t_nak();
      t_handshake();
      t_tx_space();
      t_rx_irq();
      t_sof();
      chk(reg_rdata[9:8], 2'h0);
      final_report();
   end
endmodule : testbench
